// ===== core/sppc_top.sv
// static partition and port configuration loader, device side
//
// Overview of operation
// - configuration writes are taken only during the fundamental reset
// - switch style 0xD selects multi-group operation loaded by serial loader
// - in that style all groups start disabled, all ports unattached
// - writing Active to group state activates it; loader activates first
// - port control write attaches the port to the selected group
// - setting full retrain bit restarts link training from Detect
// - writing Disabled with no action disables the port
// - group select is ignored when the new mode is Disabled
// - no-action change keeps registers; up link stays, down link trains if the new mode is Downstream or Upstream
`timescale 1ns/1ps
`default_nettype none
module sppc_top #(
    parameter int NUM_PORTS = 8
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic NRST_I,
    // reset sequence and boot vector (pins)
    input wire logic CFG_WINDOW_I,
    input wire logic [3:0] STYLE_SELECT_I,
    // per-port link state from the link layer (same clock)
    input wire logic [NUM_PORTS-1:0] LINK_UP_I,
    // register port
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    // configuration results
    output logic [1:0] GROUP_ACTIVE_O,
    output logic [NUM_PORTS*3-1:0] PORT_MODE_O,
    output logic [NUM_PORTS-1:0] PORT_GROUP_O,
    output logic [NUM_PORTS-1:0] RETRAIN_O
);
    // every assertion below runs on the core clock, off during reset
    default clocking cb_core @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    // boot pins pass two flops before use
    logic [1:0] win_sync;
    logic [3:0] style_s1, style_s2;
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            win_sync <= 2'h0;
            style_s1 <= 4'h0;
            style_s2 <= 4'h0;
        end else begin
            win_sync <= {win_sync[0], CFG_WINDOW_I};
            style_s1 <= STYLE_SELECT_I;
            style_s2 <= style_s1;
        end
    end
    wire cfg_open = win_sync[1];

    // loader phase: start at window open, done at close
    sppc_pkg::sppc_phase_t phase, next_phase;
    always_comb begin
        next_phase = phase;
        case (phase)
            sppc_pkg::PH_IDLE: if (cfg_open) next_phase = sppc_pkg::PH_LOAD;
            sppc_pkg::PH_LOAD: if (!cfg_open) next_phase = sppc_pkg::PH_DONE;
            sppc_pkg::PH_DONE: next_phase = sppc_pkg::PH_DONE;
            default: next_phase = sppc_pkg::PH_IDLE;
        endcase
    end
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) phase <= sppc_pkg::PH_IDLE;
        else phase <= next_phase;
    end

    // writes are accepted only in the load phase of multi-load style
    wire style_multi = (style_s2 == sppc_pkg::STYLE_MULTI_LOAD);
    wire wr_ok = WR_I && (phase == sppc_pkg::PH_LOAD) && style_multi;

    // address decode
    function automatic logic port_hit(input logic [7:0] a,
                                      input logic [7:0] base,
                                      input int idx);
        port_hit = (a == 8'(base + 8'(idx * 4)));
    endfunction
    wire wr_side = wr_ok && (ADDR_I == sppc_pkg::ADDR_SIDE_EFFECT);
    wire wr_drain = wr_ok && (ADDR_I == sppc_pkg::ADDR_DRAIN);
    wire wr_rdrain = wr_ok && (ADDR_I == sppc_pkg::ADDR_RST_DRAIN);
    wire wr_busrst = wr_ok && (ADDR_I == sppc_pkg::ADDR_BUS_RST);
    wire wr_g0 = wr_ok && (ADDR_I == sppc_pkg::ADDR_GROUP0);
    wire wr_g1 = wr_ok && (ADDR_I == sppc_pkg::ADDR_GROUP1);
    wire [1:0] wr_state = WDATA_I[1:0];
    wire [2:0] wr_mode = WDATA_I[sppc_pkg::MODE_LSB +: 3];
    wire wr_sel = WDATA_I[sppc_pkg::GROUP_SEL_LSB];
    wire [1:0] wr_action = WDATA_I[sppc_pkg::ACTION_LSB +: 2];

    // delay timers; zero means no delay, side effects are immediate
    logic [15:0] side_effect_delay_timer, mode_change_drain_timer;
    logic [15:0] reset_drain_timer, upstream_bus_reset_delay_timer;
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            side_effect_delay_timer <= sppc_pkg::TIMER_RESET;
            mode_change_drain_timer <= sppc_pkg::TIMER_RESET;
            reset_drain_timer <= sppc_pkg::TIMER_RESET;
            upstream_bus_reset_delay_timer <= sppc_pkg::TIMER_RESET;
        end else begin
            if (wr_side) side_effect_delay_timer <= WDATA_I[15:0];
            if (wr_drain) mode_change_drain_timer <= WDATA_I[15:0];
            if (wr_rdrain) reset_drain_timer <= WDATA_I[15:0];
            if (wr_busrst) upstream_bus_reset_delay_timer <= WDATA_I[15:0];
        end
    end

    // group control: all groups disabled after reset
    logic [1:0] group0_control, group1_control;
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            group0_control <= sppc_pkg::GROUP_DISABLED;
            group1_control <= sppc_pkg::GROUP_DISABLED;
        end else begin
            if (wr_g0) group0_control <= wr_state;
            if (wr_g1) group1_control <= wr_state;
        end
    end
    assign GROUP_ACTIVE_O = {group1_control == sppc_pkg::GROUP_ACTIVE,
                             group0_control == sppc_pkg::GROUP_ACTIVE};

    // per-port control and retrain; applied in the write cycle
    logic [2:0] port_mode [NUM_PORTS];
    logic [NUM_PORTS-1:0] group_select;
    logic [1:0] mode_change_action [NUM_PORTS];
    logic [NUM_PORTS-1:0] link_state_control0;
    logic [NUM_PORTS-1:0] retrain;
    logic [NUM_PORTS-1:0] port_wr, link_wr;
    logic [NUM_PORTS-1:0] full_retrain_request_vec, mode_rt_vec;
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
            assign port_wr[gp] = wr_ok &&
                port_hit(ADDR_I, sppc_pkg::ADDR_PORT_BASE, gp);
            assign link_wr[gp] = wr_ok &&
                port_hit(ADDR_I, sppc_pkg::ADDR_LINK_BASE, gp);
            wire new_operational = (wr_mode == sppc_pkg::PM_DOWNSTREAM) ||
                                   (wr_mode == sppc_pkg::PM_UPSTREAM);
            // down link in an operational mode trains from Detect
            assign mode_rt_vec[gp] = port_wr[gp] &&
                (wr_action == sppc_pkg::ACTION_NONE) &&
                new_operational && !LINK_UP_I[gp];
            assign full_retrain_request_vec[gp] = link_wr[gp] &&
                WDATA_I[sppc_pkg::RETRAIN_BIT];
            always_ff @(posedge CLK_I or negedge NRST_I) begin
                if (!NRST_I) begin
                    port_mode[gp] <= sppc_pkg::PM_UNATTACHED;
                    group_select[gp] <= 1'b0;
                    mode_change_action[gp] <= sppc_pkg::ACTION_NONE;
                    link_state_control0[gp] <= 1'b0;
                    retrain[gp] <= 1'b0;
                end else begin
                    if (port_wr[gp]) begin
                        port_mode[gp] <= wr_mode;
                        mode_change_action[gp] <= wr_action;
                        // disabled ports keep their old group
                        if (wr_mode != sppc_pkg::PM_DISABLED)
                            group_select[gp] <= wr_sel;
                    end
                    if (link_wr[gp])
                        link_state_control0[gp] <=
                            WDATA_I[sppc_pkg::RETRAIN_BIT];
                    // zero timers: retrain one cycle after write
                    retrain[gp] <= full_retrain_request_vec[gp] || mode_rt_vec[gp];
                end
            end
            assign PORT_MODE_O[gp*3 +: 3] = port_mode[gp];
            // retrain bit stays set in the register; the one-cycle pulse is the link's request
            assign RETRAIN_O[gp] = retrain[gp];
        end
    endgenerate
    assign PORT_GROUP_O = group_select;

    // read path: one cycle latency, unmapped reads zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = sppc_pkg::UNMAPPED_DATA;
        case (ADDR_I)
            sppc_pkg::ADDR_SIDE_EFFECT:
                rd_mux = {16'h0000, side_effect_delay_timer};
            sppc_pkg::ADDR_DRAIN:
                rd_mux = {16'h0000, mode_change_drain_timer};
            sppc_pkg::ADDR_RST_DRAIN: rd_mux = {16'h0000, reset_drain_timer};
            sppc_pkg::ADDR_BUS_RST:
                rd_mux = {16'h0000, upstream_bus_reset_delay_timer};
            sppc_pkg::ADDR_GROUP0: rd_mux = {30'h0, group0_control};
            sppc_pkg::ADDR_GROUP1: rd_mux = {30'h0, group1_control};
            sppc_pkg::ADDR_STATUS: rd_mux = {25'h0, style_s2, phase};
            default: begin
                for (int i = 0; i < NUM_PORTS; i++) begin
                    if (port_hit(ADDR_I, sppc_pkg::ADDR_PORT_BASE, i))
                        rd_mux = {22'h0, mode_change_action[i], 3'h0,
                                  group_select[i], 1'b0, port_mode[i]};
                    if (port_hit(ADDR_I, sppc_pkg::ADDR_LINK_BASE, i))
                        rd_mux = {31'h0, link_state_control0[i]};
                end
            end
        endcase
    end
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) RDATA_O <= 32'h0000_0000;
        else if (RD_I) RDATA_O <= rd_mux;
        else RDATA_O <= 32'h0000_0000;
    end

    // retrain steps: request, pulse on the asked ports, then only fresh ones
    sequence s_retrain_req;
        |full_retrain_request_vec;
    endsequence
    sequence s_retrain_set;
        (RETRAIN_O & $past(full_retrain_request_vec)) == $past(full_retrain_request_vec);
    endsequence
    sequence s_retrain_drop;
        (RETRAIN_O & ~$past(full_retrain_request_vec | mode_rt_vec)) == '0;
    endsequence

    // outside the load phase no write changes a group or a port
    AST_NO_WRITE_OUTSIDE: assert property (
        (phase != sppc_pkg::PH_LOAD) |=> $stable(GROUP_ACTIVE_O))
        else $error("group state changed outside load phase");
    AST_PORT_HELD: assert property (
        (phase != sppc_pkg::PH_LOAD) |=> $stable(PORT_MODE_O))
        else $error("port mode changed outside load phase");
    AST_STYLE_GATE: assert property (
        (WR_I && !style_multi)
        |=> ($stable(GROUP_ACTIVE_O) && $stable(PORT_MODE_O)))
        else $error("write accepted in wrong switch style");
    AST_ACTIVATE: assert property (
        (wr_g0 && wr_state == sppc_pkg::GROUP_ACTIVE)
        |=> GROUP_ACTIVE_O[0])
        else $error("group 0 not active after write");
    // any port written with a mode other than Disabled takes the selected group
    AST_ATTACH: assert property (
        ((|port_wr) && wr_mode != sppc_pkg::PM_DISABLED)
        |=> ((PORT_GROUP_O ^ {NUM_PORTS{$past(wr_sel)}})
             & $past(port_wr)) == '0)
        else $error("port not attached to selected group");
    AST_RETRAIN: assert property (
        s_retrain_req |=> s_retrain_set ##1 s_retrain_drop)
        else $error("retrain request not issued as one pulse");
    AST_DISABLE: assert property (
        (port_wr[NUM_PORTS-1] && wr_mode == sppc_pkg::PM_DISABLED)
        |=> PORT_MODE_O[(NUM_PORTS-1)*3 +: 3] == sppc_pkg::PM_DISABLED)
        else $error("last port not disabled");
    AST_IGNORE_SEL: assert property (
        ((|port_wr) && wr_mode == sppc_pkg::PM_DISABLED)
        |=> $stable(PORT_GROUP_O))
        else $error("group select taken for disabled port");
    // an up link never gets a retrain from a mode write
    AST_UP_LINK_KEPT: assert property (
        (|(port_wr & LINK_UP_I))
        |=> (RETRAIN_O & $past(port_wr & LINK_UP_I)) == '0)
        else $error("up link retrained on no-action change");
    AST_TIMER_ZERO: assert property (
        wr_side |=> side_effect_delay_timer == $past(WDATA_I[15:0]))
        else $error("timer write not applied in order");
    AST_RESET_STATE: assert property (
        (phase == sppc_pkg::PH_IDLE)
        |-> (GROUP_ACTIVE_O == 2'h0 && PORT_MODE_O == '0))
        else $error("group active or port attached before loading");
endmodule
`default_nettype wire

// ===== core/sppc_pkg.sv
// constants and types for the static partition and port configuration block
package sppc_pkg;
    // register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] ADDR_SIDE_EFFECT = 8'h00;
    localparam logic [7:0] ADDR_DRAIN = 8'h04;
    localparam logic [7:0] ADDR_RST_DRAIN = 8'h08;
    localparam logic [7:0] ADDR_BUS_RST = 8'h0C;
    localparam logic [7:0] ADDR_GROUP0 = 8'h10;
    localparam logic [7:0] ADDR_GROUP1 = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_PORT_BASE = 8'h40;
    localparam logic [7:0] ADDR_LINK_BASE = 8'h80;
    // field positions
    localparam int MODE_LSB = 0;
    localparam int GROUP_SEL_LSB = 4;
    localparam int ACTION_LSB = 8;
    localparam int RETRAIN_BIT = 0;
    // switch style value selecting multi-group loading
    localparam logic [3:0] STYLE_MULTI_LOAD = 4'hD;
    // group control state encodings
    localparam logic [1:0] GROUP_DISABLED = 2'h0;
    localparam logic [1:0] GROUP_ACTIVE = 2'h1;
    // action encodings
    localparam logic [1:0] ACTION_NONE = 2'h0;
    // reset values of the delay timers (defaults, not documented figures)
    localparam logic [15:0] TIMER_RESET = 16'h0010;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    // operating modes of a port
    typedef enum logic [2:0] {
        PM_UNATTACHED = 3'h0,
        PM_DOWNSTREAM = 3'h1,
        PM_UPSTREAM = 3'h2,
        PM_DISABLED = 3'h3
    } sppc_mode_t;
    // loader phase, one-hot
    typedef enum logic [2:0] {
        PH_IDLE = 3'h1,
        PH_LOAD = 3'h2,
        PH_DONE = 3'h4
    } sppc_phase_t;
endpackage

// ===== test/sppc_loader.sv
// loader model: drives the block's register port like a serial loader
`timescale 1ns/1ps
`default_nettype none
module sppc_loader (
    // clock
    input wire logic CLK_I,
    // register port
    output logic [7:0] ADDR_O,
    output logic [31:0] WDATA_O,
    output logic WR_O,
    output logic RD_O,
    input wire logic [31:0] RDATA_I
);
    // idle at time zero, address parked off the map
    initial begin
        ADDR_O = 8'hFC;
        WDATA_O = 32'h0;
        WR_O = 1'b0;
        RD_O = 1'b0;
    end
    // one-cycle write; released lines show the inverse, not stale data
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_I);
        ADDR_O <= a;
        WDATA_O <= d;
        WR_O <= 1'b1;
        @(posedge CLK_I);
        WR_O <= 1'b0;
        ADDR_O <= ~a;
        WDATA_O <= ~d;
    endtask
    // one-cycle read; data taken in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK_I);
        ADDR_O <= a;
        RD_O <= 1'b1;
        @(posedge CLK_I);
        RD_O <= 1'b0;
        ADDR_O <= ~a;
        #1 d = RDATA_I;
    endtask
endmodule
`default_nettype wire

// ===== test/static_partition_port_config_test.sv
// self-checking bench for the partition and port configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
    $display("ERROR %0t value %h expected %h", $time, a, b); end end
module static_partition_port_config_test;
    localparam int NP = 8;
    logic clk = 1'b0, nrst = 1'b0, win = 1'b0, live = 1'b0;
    logic [3:0] style = 4'h3;
    logic [NP-1:0] lup = '0, eg = '0, er, retr, grp;
    logic [NP*3-1:0] em = '0, mode;
    logic [1:0] act;
    logic [7:0] addr;
    logic [31:0] wd, rdat, d;
    logic wr, rd;
    logic [31:0] seed = 32'h0000_0087;
    int failures = 0, checks_done = 0, cycles = 0;
    sppc_top #(.NUM_PORTS(NP)) sppc_top_i (.CLK_I(clk), .NRST_I(nrst),
        .CFG_WINDOW_I(win), .STYLE_SELECT_I(style), .LINK_UP_I(lup),
        .ADDR_I(addr), .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdat),
        .GROUP_ACTIVE_O(act), .PORT_MODE_O(mode), .PORT_GROUP_O(grp),
        .RETRAIN_O(retr));
    sppc_loader sppc_loader_i (.CLK_I(clk), .ADDR_O(addr), .WDATA_O(wd),
        .WR_O(wr), .RD_O(rd), .RDATA_I(rdat));
    // 25 MHz clock
    initial forever #20 clk = ~clk;
    // hang guard, far above the roughly 100 cycles of the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            $display("ERROR %0t run did not finish", $time);
            close_out();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic start(input logic [3:0] s);
        @(posedge clk);
        nrst <= 1'b0;
        win <= 1'b0;
        style <= s;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
    endtask
    // port write with no action; model updates only while loading
    task automatic port_w(input int p, input logic [2:0] m, input logic g);
        sppc_loader_i.wr(sppc_pkg::ADDR_PORT_BASE + 8'(4 * p),
            {22'h0, sppc_pkg::ACTION_NONE, 3'h0, g, 1'b0, m});
        #1 er = '0;
        if (live) begin
            em[3*p+:3] = m;
            if (m != sppc_pkg::PM_DISABLED) eg[p] = g;
            if ((m == sppc_pkg::PM_DOWNSTREAM || m == sppc_pkg::PM_UPSTREAM)
                && !lup[p]) er[p] = 1'b1;
        end
        `CHK(mode, em)
        `CHK(grp, eg)
        `CHK(retr, er)
    endtask
    // full retrain after a downstream assignment
    task automatic retrain(input int p);
        sppc_loader_i.wr(sppc_pkg::ADDR_LINK_BASE + 8'(4 * p), 32'h1);
        #1 `CHK(retr, NP'(1) << p)
        @(posedge clk);
        #1 `CHK(retr, NP'(0))
    endtask
    task automatic timers(input logic [31:0] v);
        for (int i = 0; i < 4; i++) begin
            sppc_loader_i.wr(8'(4 * i), v);
            sppc_loader_i.rd(8'(4 * i), d);
            `CHK(d, v)
        end
    endtask
    initial begin
        // wrong switch style: loading refused
        start(4'h3);
        @(posedge clk);
        win <= 1'b1;
        repeat (4) @(posedge clk);
        port_w(1, sppc_pkg::PM_DOWNSTREAM, 1'b0);
        $display("test style refusal done");
        // second reset with loading style, write before the window opens
        start(sppc_pkg::STYLE_MULTI_LOAD);
        lup <= NP'(xs());
        port_w(2, sppc_pkg::PM_UPSTREAM, 1'b1);
        @(posedge clk);
        win <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK({act, mode, grp}, '0)
        live = 1'b1;
        sppc_loader_i.rd(sppc_pkg::ADDR_STATUS, d);
        `CHK(d, {25'h0, sppc_pkg::STYLE_MULTI_LOAD, 3'h2})
        sppc_loader_i.rd(8'h3C, d);
        `CHK(d, 32'h0)
        timers(32'h0);
        sppc_loader_i.wr(sppc_pkg::ADDR_GROUP0, 32'h1);
        #1 `CHK(act, 2'h1)
        sppc_loader_i.wr(sppc_pkg::ADDR_GROUP1, 32'h1);
        #1 `CHK(act, 2'h3)
        for (int i = 0; i < 4; i++) begin
            port_w(i + 1 + i / 2, sppc_pkg::PM_DOWNSTREAM, 1'(i / 2));
            retrain(i + 1 + i / 2);
        end
        port_w(0, sppc_pkg::PM_UPSTREAM, 1'b0);
        port_w(3, sppc_pkg::PM_UPSTREAM, 1'b1);
        // port 3 reads back upstream, group 1, no action
        sppc_loader_i.rd(sppc_pkg::ADDR_PORT_BASE + 8'h0C, d);
        `CHK(d, 32'h0000_0012)
        for (int p = 6; p < NP; p++)
            port_w(p, sppc_pkg::PM_DISABLED, 1'(xs()));
        timers(32'(sppc_pkg::TIMER_RESET));
        $display("test load sequence done");
        // after the window closes nothing more is taken
        @(posedge clk);
        win <= 1'b0;
        repeat (4) @(posedge clk);
        live = 1'b0;
        port_w(0, sppc_pkg::PM_DISABLED, 1'b1);
        $display("test closed window done");
        close_out();
    end
endmodule
`default_nettype wire
